// >>> src/cwc_bank.sv
`timescale 1ns/1ns
// How it works
// - transmit state read copies it into snapshot
// - transmit write keeps mismatched bits, flags inhibit
// - receive A read copies it into snapshot
// - receive A write keeps mismatched bits, flags inhibit
// - receive B read copies it into snapshot
// - receive B write keeps mismatched bits, flags inhibit
// - transmit snapshot bits mirror transmit fields one-for-one
// - receive A snapshot bits mirror A flags
// - receive B snapshot bits mirror B flags
module cwc_bank #(
	parameter int DATA_W = cwc_pkg::DATA_W
) (
	// clock, reset, enable
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// control bus access
	input wire cwc_pkg::cwc_bus_req_type cbReq,
	output logic [cwc_pkg::DATA_W-1:0] cbRdata,
	output logic cbRdValid,
	// hardware updates, index 0 transmit, 1 receive A, 2 receive B
	input wire cwc_pkg::cwc_hw_upd_type hwUpd [cwc_pkg::NUM_PROT],
	// live protected register contents
	output logic [cwc_pkg::NUM_PROT-1:0][cwc_pkg::DATA_W-1:0] liveOut,
	// pulse toward the interrupt condition register
	output logic condWriteBlockFlag
);
	import cwc_pkg::*;

	// the struct carriers fix the width
	initial begin
		if (DATA_W != cwc_pkg::DATA_W) begin
			$error("cwc_bank supports only the package data width");
		end
	end

	// live and snapshot storage
	logic [NUM_PROT-1:0][DATA_W-1:0] live;
	logic [NUM_PROT-1:0][DATA_W-1:0] snap;
	// per-register decode and compare results
	logic [NUM_PROT-1:0] liveRd;
	logic [NUM_PROT-1:0] liveWr;
	logic [NUM_PROT-1:0] snapRd;
	logic [NUM_PROT-1:0] snapWr;
	logic [NUM_PROT-1:0] blocked;
	logic [NUM_PROT-1:0][DATA_W-1:0] mismatch;
	logic [NUM_PROT-1:0][DATA_W-1:0] next_live;
	logic [NUM_PROT-1:0][DATA_W-1:0] next_snap;
	logic [NUM_PROT-1:0][DATA_W-1:0] rdTerm;
	// read mux result and any hit
	logic [DATA_W-1:0] next_rdata;
	logic anyHit;
	logic anyBlocked;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_PROT; gi++) begin : g_prot
			// the bus decode for this pair
			assign liveRd[gi] = cbReq.rd & (cbReq.addr == LIVE_ADDRS[gi]);
			assign liveWr[gi] = cbReq.wr & (cbReq.addr == LIVE_ADDRS[gi]);
			assign snapRd[gi] = cbReq.rd & (cbReq.addr == SNAP_ADDRS[gi]);
			assign snapWr[gi] = cbReq.wr & (cbReq.addr == SNAP_ADDRS[gi]);
			// bits where live differs from the snapshot, by device or bus change since the last live read or snapshot write
			assign mismatch[gi] = live[gi] ^ snap[gi];
			// write lands only on matching bits
			wire [DATA_W-1:0] written = (live[gi] & mismatch[gi]) | (cbReq.wdata & ~mismatch[gi]);
			wire [DATA_W-1:0] afterWr = liveWr[gi] ? written : live[gi];
			// hardware set beats any clear, bus or hardware
			assign next_live[gi] = (afterWr & ~hwUpd[gi].clr) | hwUpd[gi].set;
			// read copies whole byte bit for bit
			assign next_snap[gi] = liveRd[gi] ? live[gi] : (snapWr[gi] ? cbReq.wdata : snap[gi]);
			// a write that meets a changed bit is inhibited
			assign blocked[gi] = liveWr[gi] & (|mismatch[gi]);
			// read data contribution
			assign rdTerm[gi] = ({DATA_W{liveRd[gi]}} & live[gi]) | ({DATA_W{snapRd[gi]}} & snap[gi]);

			// live and snapshot registers
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					live[gi] <= LIVE_RESET;
					snap[gi] <= SNAP_RESET;
				end else if (ce) begin
					live[gi] <= next_live[gi];
					snap[gi] <= next_snap[gi];
				end
			end

			// read captures the live value
			snap_capture_a: assert property (@(posedge clk) disable iff (rst)
				(ce && liveRd[gi]) |=> (snap[gi] == $past(live[gi])))
				else $error("snapshot did not capture live value on read");

			// mismatched bits never move by a bus write
			write_block_a: assert property (@(posedge clk) disable iff (rst)
				(ce && liveWr[gi] && hwUpd[gi].set == '0 && hwUpd[gi].clr == '0)
				|=> (((live[gi] ^ $past(live[gi])) & $past(mismatch[gi])) == '0))
				else $error("write changed a bit that differs from its snapshot");

			// matching bits take the written data
			match_take_a: assert property (@(posedge clk) disable iff (rst)
				(ce && liveWr[gi] && hwUpd[gi].set == '0 && hwUpd[gi].clr == '0)
				|=> ((live[gi] & ~$past(mismatch[gi])) ==
					($past(cbReq.wdata) & ~$past(mismatch[gi]))))
				else $error("matching bits did not take written value");

			// inhibited write raises the flag next cycle
			inhibit_raise_a: assert property (@(posedge clk) disable iff (rst)
				(ce && liveWr[gi] && mismatch[gi] != '0) |=> condWriteBlockFlag)
				else $error("inhibit flag missing after blocked write");

			// hardware set survives a same-cycle clearing write
			hw_set_wins_a: assert property (@(posedge clk) disable iff (rst)
				(ce && hwUpd[gi].set != '0) |=> ((live[gi] & $past(hwUpd[gi].set)) == $past(hwUpd[gi].set)))
				else $error("hardware set lost against a clear");

			// hardware clear empties its bits when no set competes
			hw_clr_wins_a: assert property (@(posedge clk) disable iff (rst)
				(ce && hwUpd[gi].clr != '0 && hwUpd[gi].set == '0)
				|=> ((live[gi] & $past(hwUpd[gi].clr)) == '0))
				else $error("hardware clear did not land");

			// live holds with no write and no update
			live_idle_a: assert property (@(posedge clk) disable iff (rst)
				(ce && !liveWr[gi] && hwUpd[gi].set == '0 && hwUpd[gi].clr == '0)
				|=> (live[gi] == $past(live[gi])))
				else $error("live register moved without cause");

			// clock enable low freezes the live register
			live_freeze_a: assert property (@(posedge clk) disable iff (rst)
				!ce
				|=> (live[gi] == $past(live[gi])))
				else $error("live register moved while frozen");

			// clock enable low freezes the snapshot
			snap_freeze_a: assert property (@(posedge clk) disable iff (rst)
				!ce
				|=> (snap[gi] == $past(snap[gi])))
				else $error("snapshot moved while frozen");

			// snapshot only moves on a live read or its own write
			snap_hold_a: assert property (@(posedge clk) disable iff (rst)
				(ce && !liveRd[gi] && !snapWr[gi])
				|=> (snap[gi] == $past(snap[gi])))
				else $error("snapshot moved without a read");

			// direct snapshot write lands whole
			snap_write_a: assert property (@(posedge clk) disable iff (rst)
				(ce && snapWr[gi] && !liveRd[gi])
				|=> (snap[gi] == $past(cbReq.wdata)))
				else $error("snapshot write did not land");

			// write with no changed bits lands whole
			clean_write_a: assert property (@(posedge clk) disable iff (rst)
				(ce && liveWr[gi] && mismatch[gi] == '0 && hwUpd[gi].set == '0 && hwUpd[gi].clr == '0)
				|=> (live[gi] == $past(cbReq.wdata)))
				else $error("clean write did not land whole");

			// live read returns the pre-edge live value
			live_rdata_a: assert property (@(posedge clk) disable iff (rst)
				(ce && liveRd[gi])
				|=> (cbRdata == $past(live[gi])))
				else $error("live read returned wrong data");

			// snapshot read returns the snapshot
			snap_rdata_a: assert property (@(posedge clk) disable iff (rst)
				(ce && snapRd[gi])
				|=> (cbRdata == $past(snap[gi])))
				else $error("snapshot read returned wrong data");

			// a read alone leaves the live value alone
			read_keeps_live_a: assert property (@(posedge clk) disable iff (rst)
				(ce && liveRd[gi] && !liveWr[gi] && hwUpd[gi].set == '0 && hwUpd[gi].clr == '0)
				|=> (live[gi] == $past(live[gi])))
				else $error("read disturbed live register");

			// blocked write raises the inhibit pulse
			blocked_flag_a: assert property (@(posedge clk) disable iff (rst)
				(ce && blocked[gi])
				|=> (condWriteBlockFlag == 1'b1))
				else $error("blocked write left flag low");
		end
	endgenerate

	// read mux, unmapped offsets read as zero
	always_comb begin
		next_rdata = UNMAPPED_READ;
		for (int i = 0; i < NUM_PROT; i++) begin
			next_rdata = next_rdata | rdTerm[i];
		end
	end
	assign anyHit = cbReq.rd;
	assign anyBlocked = |blocked;

	// registered read answer and inhibit pulse
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cbRdata <= UNMAPPED_READ;
			cbRdValid <= 1'b0;
			condWriteBlockFlag <= 1'b0;
		end else if (ce) begin
			cbRdata <= anyHit ? next_rdata : UNMAPPED_READ;
			cbRdValid <= anyHit;
			condWriteBlockFlag <= anyBlocked;
		end
	end

	// live contents straight from the registers
	assign liveOut = live;

	// no flag without a blocked write
	no_false_inhibit_a: assert property (@(posedge clk) disable iff (rst)
		(ce && !anyBlocked) |=> !condWriteBlockFlag)
		else $error("inhibit flag raised without blocked write");

	// every read answers one cycle later
	read_answer_a: assert property (@(posedge clk) disable iff (rst)
		(ce && cbReq.rd) |=> cbRdValid)
		else $error("read not answered in one cycle");

	// smoother field lands in its snapshot bit
	tx_field_map_a: assert property (@(posedge clk) disable iff (rst)
		(ce && liveRd[IDX_TX]) |=> (snap[IDX_TX][SMOOTHER_ON_BIT] == $past(live[IDX_TX][SMOOTHER_ON_BIT])))
		else $error("transmit snapshot bit map broken");

	// line change flag lands in its snapshot bit
	rxa_flag_map_a: assert property (@(posedge clk) disable iff (rst)
		(ce && liveRd[IDX_RXA]) |=> (snap[IDX_RXA][LINE_CHANGE_BIT] == $past(live[IDX_RXA][LINE_CHANGE_BIT])))
		else $error("receive A snapshot bit map broken");

	// super idle flag lands in its snapshot bit
	rxb_flag_map_a: assert property (@(posedge clk) disable iff (rst)
		(ce && liveRd[IDX_RXB]) |=> (snap[IDX_RXB][SUPER_IDLE_BIT] == $past(live[IDX_RXB][SUPER_IDLE_BIT])))
		else $error("receive B snapshot bit map broken");

	// clock enable low freezes the read data
	rdata_freeze_a: assert property (@(posedge clk) disable iff (rst)
		!ce
		|=> (cbRdata == $past(cbRdata)))
		else $error("read data moved while frozen");

	// clock enable low freezes the read valid
	valid_freeze_a: assert property (@(posedge clk) disable iff (rst)
		!ce
		|=> (cbRdValid == $past(cbRdValid)))
		else $error("read valid moved while frozen");

	// clock enable low freezes the inhibit pulse
	flag_freeze_a: assert property (@(posedge clk) disable iff (rst)
		!ce
		|=> (condWriteBlockFlag == $past(condWriteBlockFlag)))
		else $error("inhibit flag moved while frozen");

	// no read, no answer
	no_read_quiet_a: assert property (@(posedge clk) disable iff (rst)
		(ce && !cbReq.rd)
		|=> (!cbRdValid && cbRdata == UNMAPPED_READ))
		else $error("answer without a read");

	// unmapped reads give the default value
	unmapped_read_a: assert property (@(posedge clk) disable iff (rst)
		(ce && cbReq.rd && liveRd == '0 && snapRd == '0)
		|=> (cbRdata == UNMAPPED_READ))
		else $error("unmapped read gave data");

	// no write, no inhibit pulse
	flag_needs_write_a: assert property (@(posedge clk) disable iff (rst)
		(ce && !cbReq.wr)
		|=> !condWriteBlockFlag)
		else $error("inhibit flag without a write");

	// transmit mode field lands in its snapshot bits
	tx_mode_map_a: assert property (@(posedge clk) disable iff (rst)
		(ce && liveRd[IDX_TX]) |=> (snap[IDX_TX][TX_MODE_LSB +: TX_MODE_W] ==
			$past(live[IDX_TX][TX_MODE_LSB +: TX_MODE_W])))
		else $error("transmit mode snapshot map broken");

	// injection control field lands in its snapshot bits
	inj_ctrl_map_a: assert property (@(posedge clk) disable iff (rst)
		(ce && liveRd[IDX_TX]) |=> (snap[IDX_TX][INJ_CTRL_LSB +: INJ_CTRL_W] ==
			$past(live[IDX_TX][INJ_CTRL_LSB +: INJ_CTRL_W])))
		else $error("injection control snapshot map broken");

	// request parity bit lands in its snapshot bit
	parity_map_a: assert property (@(posedge clk) disable iff (rst)
		(ce && liveRd[IDX_TX]) |=> (snap[IDX_TX][REQUEST_PARITY_ON_BIT] ==
			$past(live[IDX_TX][REQUEST_PARITY_ON_BIT])))
		else $error("request parity snapshot map broken");

	// transmit reserved bit lands in its snapshot bit
	tx_resv_map_a: assert property (@(posedge clk) disable iff (rst)
		(ce && liveRd[IDX_TX]) |=> (snap[IDX_TX][TX_RESERVED_BIT] ==
			$past(live[IDX_TX][TX_RESERVED_BIT])))
		else $error("transmit reserved snapshot map broken");

	// no signal flag lands in its snapshot bit
	rxa_nosig_map_a: assert property (@(posedge clk) disable iff (rst)
		(ce && liveRd[IDX_RXA]) |=> (snap[IDX_RXA][NO_SIGNAL_BIT] ==
			$past(live[IDX_RXA][NO_SIGNAL_BIT])))
		else $error("no signal snapshot map broken");

	// unknown invalid flag lands in its snapshot bit
	rxa_unknown_map_a: assert property (@(posedge clk) disable iff (rst)
		(ce && liveRd[IDX_RXA]) |=> (snap[IDX_RXA][UNKNOWN_INVALID_BIT] ==
			$past(live[IDX_RXA][UNKNOWN_INVALID_BIT])))
		else $error("unknown invalid snapshot map broken");

	// idle line flag lands in its snapshot bit
	rxb_idle_map_a: assert property (@(posedge clk) disable iff (rst)
		(ce && liveRd[IDX_RXB]) |=> (snap[IDX_RXB][IDLE_LINE_BIT] ==
			$past(live[IDX_RXB][IDLE_LINE_BIT])))
		else $error("idle line snapshot map broken");

	// receive B reserved bit lands in its snapshot bit
	rxb_resv_map_a: assert property (@(posedge clk) disable iff (rst)
		(ce && liveRd[IDX_RXB]) |=> (snap[IDX_RXB][RXB_RESERVED_BIT] ==
			$past(live[IDX_RXB][RXB_RESERVED_BIT])))
		else $error("receive B reserved snapshot map broken");
endmodule

// >>> src/cwc_pkg.sv
package cwc_pkg;
	// data and address widths of the control bus
	localparam int DATA_W = 8;
	localparam int ADDR_W = 5;
	// number of protected register pairs
	localparam int NUM_PROT = 3;
	// index of each protected register in the arrays
	localparam int IDX_TX = 0;
	localparam int IDX_RXA = 1;
	localparam int IDX_RXB = 2;
	// offsets of the live protected registers
	localparam logic [ADDR_W-1:0] ADDR_TX_STATE_REG = 5'h04;
	localparam logic [ADDR_W-1:0] ADDR_RX_COND_A_REG = 5'h09;
	localparam logic [ADDR_W-1:0] ADDR_RX_COND_B_REG = 5'h0a;
	// offsets of the snapshot registers
	localparam logic [ADDR_W-1:0] ADDR_TX_STATE_SNAPSHOT = 5'h1b;
	localparam logic [ADDR_W-1:0] ADDR_RX_COND_A_SNAPSHOT = 5'h1c;
	localparam logic [ADDR_W-1:0] ADDR_RX_COND_B_SNAPSHOT = 5'h1d;
	// offset tables, entry 0 is the transmit pair
	localparam logic [NUM_PROT-1:0][ADDR_W-1:0] LIVE_ADDRS =
		{ADDR_RX_COND_B_REG, ADDR_RX_COND_A_REG, ADDR_TX_STATE_REG};
	localparam logic [NUM_PROT-1:0][ADDR_W-1:0] SNAP_ADDRS =
		{ADDR_RX_COND_B_SNAPSHOT, ADDR_RX_COND_A_SNAPSHOT, ADDR_TX_STATE_SNAPSHOT};
	// reset values
	localparam logic [DATA_W-1:0] LIVE_RESET = 8'h00;
	localparam logic [DATA_W-1:0] SNAP_RESET = 8'h00;
	localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;
	// transmit state field positions
	localparam int TX_MODE_LSB = 0;
	localparam int TX_MODE_W = 3;
	localparam int INJ_CTRL_LSB = 3;
	localparam int INJ_CTRL_W = 2;
	localparam int SMOOTHER_ON_BIT = 5;
	localparam int REQUEST_PARITY_ON_BIT = 6;
	localparam int TX_RESERVED_BIT = 7;
	// receive condition A flag positions
	localparam int NO_SIGNAL_BIT = 0;
	localparam int QUIET_LINE_BIT = 1;
	localparam int HALT_LINE_BIT = 2;
	localparam int MASTER_LINE_BIT = 3;
	localparam int NOISE_LINE_BIT = 4;
	localparam int NOISE_LIMIT_BIT = 5;
	localparam int LINE_CHANGE_BIT = 6;
	localparam int UNKNOWN_INVALID_BIT = 7;
	// receive condition B flag positions
	localparam int IDLE_LINE_BIT = 0;
	localparam int DWELL_LIMIT_BIT = 1;
	localparam int ACTIVE_LINE_BIT = 2;
	localparam int UNKNOWN_VALID_BIT = 3;
	localparam int CASCADE_SYNC_EVENT_BIT = 4;
	localparam int ELASTIC_BUFFER_SLIP_BIT = 5;
	localparam int SUPER_IDLE_BIT = 6;
	localparam int RXB_RESERVED_BIT = 7;
	// one control bus access
	typedef struct packed {
		logic rd;
		logic wr;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} cwc_bus_req_type;
	// one hardware update of a protected register
	typedef struct packed {
		logic [DATA_W-1:0] set;
		logic [DATA_W-1:0] clr;
	} cwc_hw_upd_type;
endpackage

// >>> verification/cwc_host_model.sv
`timescale 1ns/1ns
// behavioural management host, one access at a time
module cwc_host_model (
	// clock
	input wire logic clk,
	// control bus toward the bank
	output cwc_pkg::cwc_bus_req_type cbReq,
	input wire logic [cwc_pkg::DATA_W-1:0] cbRdata,
	input wire logic cbRdValid,
	input wire logic condWriteBlockFlag
);
	import cwc_pkg::*;
	initial cbReq = '0;
	// one-cycle read strobe, data taken in the answer cycle
	task automatic busRead(input logic [4:0] a, output logic [7:0] d);
		@(posedge clk) #1 cbReq = '{1'b1, 1'b0, a, 8'h00};
		@(posedge clk) #1 cbReq = '{1'b0, 1'b0, ~a, 8'hff};
		d = cbRdValid ? cbRdata : 8'hxx;
	endtask
	// one-cycle write strobe, inhibit pulse taken in the next cycle
	task automatic busWrite(input logic [4:0] a, input logic [7:0] d, output logic f);
		@(posedge clk) #1 cbReq = '{1'b0, 1'b1, a, d};
		@(posedge clk) #1 cbReq = '{1'b0, 1'b0, ~a, ~d};
		f = condWriteBlockFlag;
	endtask
endmodule

// >>> verification/conditional_write_compare_tb.sv
`timescale 1ns/1ns
// bench for the conditional write bank
module conditional_write_compare_tb;
	import cwc_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	cwc_bus_req_type cbReq;
	logic [DATA_W-1:0] cbRdata;
	logic cbRdValid;
	logic condWriteBlockFlag;
	logic f;
	logic [DATA_W-1:0] d;
	logic [NUM_PROT-1:0][DATA_W-1:0] liveOut;
	cwc_hw_upd_type hwUpd [NUM_PROT];
	int fail_count = 0;
	int samples_checked = 0;
	int cycles = 0;
	// 10 MHz clock
	always #50 clk = ~clk;
	cwc_bank dut_u (
		.clk(clk), .rst(rst), .ce(ce), .cbReq(cbReq), .cbRdata(cbRdata),
		.cbRdValid(cbRdValid), .hwUpd(hwUpd), .liveOut(liveOut),
		.condWriteBlockFlag(condWriteBlockFlag)
	);
	cwc_host_model host_u (
		.clk(clk), .cbReq(cbReq), .cbRdata(cbRdata), .cbRdValid(cbRdValid),
		.condWriteBlockFlag(condWriteBlockFlag)
	);
	// compare and count
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	// verdict and end of run
	task automatic summarize();
		$display("checks %0d, mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// one-cycle device set pulse on a protected register
	task automatic hwSet(input int i, input logic [7:0] m);
		@(posedge clk) #1 hwUpd[i].set = m;
		@(posedge clk) #1 hwUpd[i].set = 8'h00;
	endtask
	// cycle ceiling against a hang
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			fail_count++;
			summarize();
		end
	end
	// main sequence, one pass per protected pair
	initial begin
		foreach (hwUpd[i]) hwUpd[i] = '0;
		repeat (12) @(posedge clk);
		#1 rst = 1'b0;
		host_u.busRead(5'h1f, d);
		check(d, UNMAPPED_READ);
		for (int i = 0; i < NUM_PROT; i++) begin
			host_u.busRead(SNAP_ADDRS[i], d);
			check(d, SNAP_RESET);
			host_u.busRead(LIVE_ADDRS[i], d);
			check(d, LIVE_RESET);
			// device changes bits, host reads to capture them
			hwSet(i, 8'h81);
			host_u.busRead(LIVE_ADDRS[i], d);
			check(d, 8'h81);
			host_u.busRead(SNAP_ADDRS[i], d);
			check(d, 8'h81);
			// write after read goes through whole
			host_u.busWrite(LIVE_ADDRS[i], 8'h3c, f);
			check({7'h00, f}, 8'h00);
			check(liveOut[i], 8'h3c);
			// device sets bit 1 after the read: only that bit is kept
			host_u.busRead(LIVE_ADDRS[i], d);
			hwSet(i, 8'h02);
			host_u.busWrite(LIVE_ADDRS[i], 8'h00, f);
			check({7'h00, f}, 8'h01);
			check(liveOut[i], 8'h02);
			// snapshot written directly to match, write then lands
			host_u.busWrite(SNAP_ADDRS[i], 8'h02, f);
			host_u.busWrite(LIVE_ADDRS[i], 8'h00, f);
			check({7'h00, f}, 8'h00);
			check(liveOut[i], 8'h00);
		end
		// clock enable low: a device set must not land
		@(posedge clk) #1 ce = 1'b0;
		hwUpd[0].set = 8'hff;
		repeat (3) @(posedge clk);
		#1 hwUpd[0].set = 8'h00;
		ce = 1'b1;
		check(liveOut[0], 8'h00);
		summarize();
	end
endmodule
